// ### rtl/agu_pkg.sv
package agu_pkg;
    localparam int DATA_W = 16;
    localparam int SEL_W = 4;
    localparam int APB_ADDR_W = 12;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CIRC_CTRL = 8'h46;
    localparam logic [7:0] IDX_PRI_START = 8'h48;
    localparam logic [7:0] IDX_PRI_END = 8'h4A;
    localparam logic [7:0] IDX_SEC_START = 8'h4C;
    localparam logic [7:0] IDX_SEC_END = 8'h4E;
    localparam logic [7:0] IDX_BIT_REV = 8'h50;
    localparam logic [7:0] IDX_PRI_EA = 8'h60;
    localparam logic [7:0] IDX_SEC_EA = 8'h61;
    localparam logic [APB_ADDR_W-1:0] ADDR_CIRC_CTRL = {2'h0, IDX_CIRC_CTRL, 2'h0};
    localparam logic [APB_ADDR_W-1:0] ADDR_PRI_START = {2'h0, IDX_PRI_START, 2'h0};
    localparam logic [APB_ADDR_W-1:0] ADDR_PRI_END = {2'h0, IDX_PRI_END, 2'h0};
    localparam logic [APB_ADDR_W-1:0] ADDR_SEC_START = {2'h0, IDX_SEC_START, 2'h0};
    localparam logic [APB_ADDR_W-1:0] ADDR_SEC_END = {2'h0, IDX_SEC_END, 2'h0};
    localparam logic [APB_ADDR_W-1:0] ADDR_BIT_REV = {2'h0, IDX_BIT_REV, 2'h0};
    localparam logic [APB_ADDR_W-1:0] ADDR_PRI_EA = {2'h0, IDX_PRI_EA, 2'h0};
    localparam logic [APB_ADDR_W-1:0] ADDR_SEC_EA = {2'h0, IDX_SEC_EA, 2'h0};
    // circ control field layout
    localparam int PRI_CIRC_EN_BIT = 15;
    localparam int SEC_CIRC_EN_BIT = 14;
    localparam int REV_SEL_LSB = 8;
    localparam int SEC_SEL_LSB = 4;
    localparam int PRI_SEL_LSB = 0;
    localparam int REV_EN_BIT = 15;
    localparam logic [SEL_W-1:0] SEL_DISABLED = 4'hF;
    localparam logic [DATA_W-1:0] CIRC_CTRL_MASK = 16'hCFFF;
    localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] START_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] END_RESET = 16'h0001;
    localparam logic [DATA_W-1:0] BIT_REV_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
    // file-register direct field width and near region
    localparam int FILE_ADDR_W = 13;
    localparam int NEAR_BYTES = 8192;
    localparam int LIT_SHORT_W = 5;
    localparam int LIT_LONG_W = 10;
    typedef enum logic [2:0] {
        MODE_FILE,
        MODE_REG,
        MODE_IND,
        MODE_POST,
        MODE_PRE,
        MODE_REGOFF,
        MODE_LITOFF,
        MODE_LIT
    } agu_mode_type;
endpackage

// ### rtl/agu_top.sv
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
// Functional notes
// [RULE1] two independent address generators, primary and secondary
// [RULE2] secondary serves word reads only
// [RULE3] linear, circular and bit-reversed addressing supported
// [RULE4] bit-reverse only in data space
// [RULE5] 13-bit field addresses lowest 8192 bytes
// [RULE6] direct memory operand uses register zero
// [RULE7] result to memory or register zero, multiply excepted
// [RULE8] move direct reaches whole data space
// [RULE9] memory-direct address comes from instruction
// [RULE10] register direct reads register, no memory access
// [RULE11] indirect EA is pointer, pointer unchanged
// [RULE12] post-modify: old pointer is EA, then updated
// [RULE13] pre-modify: updated pointer is EA, written back
// [RULE14] register offset: pointer plus offset register
// [RULE15] literal offset: pointer plus instruction literal
// [RULE16] first source is base register, direct only
// [RULE17] second source register, memory or 5-bit literal
// [RULE18] result to register or memory location
// [RULE19] arithmetic modes plus 5 or 10 bit literals
// [RULE20] primary circular needs bit 15 and selector not 15
// [RULE21] secondary circular needs bit 14, selector not 15
// [RULE22] bit-reverse needs enable, selector, increment mode
// [RULE23] 16-bit byte addresses, pointer wraps modulo 2^16
module agu_top #(
    parameter int NUM_REGS = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [agu_pkg::APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic priReq,
    input wire agu_pkg::agu_mode_type priMode,
    input wire logic [agu_pkg::SEL_W-1:0] priPtrSel,
    input wire logic [agu_pkg::SEL_W-1:0] priOffSel,
    input wire logic [agu_pkg::DATA_W-1:0] priLit,
    input wire logic priLitLong,
    input wire logic priMoveFull,
    input wire logic [agu_pkg::DATA_W-1:0] priModAmt,
    input wire logic priWrite,
    input wire logic priProgSpace,
    input wire logic [agu_pkg::SEL_W-1:0] baseSel,
    input wire logic secReq,
    input wire agu_pkg::agu_mode_type secMode,
    input wire logic [agu_pkg::SEL_W-1:0] secPtrSel,
    input wire logic [agu_pkg::SEL_W-1:0] secOffSel,
    input wire logic [agu_pkg::DATA_W-1:0] secModAmt,
    input wire logic secWrite,
    input wire logic secByte,
    input wire logic resultWrEn,
    input wire logic resultToZero,
    input wire logic [agu_pkg::SEL_W-1:0] resultSel,
    input wire logic [agu_pkg::DATA_W-1:0] resultData,
    output logic [agu_pkg::DATA_W-1:0] priEa,
    output logic priEaValid,
    output logic priMemAccess,
    output logic [agu_pkg::DATA_W-1:0] priOperand,
    output logic [agu_pkg::DATA_W-1:0] baseOperand,
    output logic priBitRevActive,
    output logic [agu_pkg::DATA_W-1:0] secEa,
    output logic secEaValid,
    output logic secRefused
);
    localparam int DW = agu_pkg::DATA_W;

    if (NUM_REGS != 16) begin : gBadRegs
        $error("agu_top: pointer selectors need exactly 16 working registers");
    end

    function automatic logic [DW-1:0] rev16(input logic [DW-1:0] v);
        logic [DW-1:0] r;
        r = '0;
        for (int i = 0; i < DW; i++) begin
            r[i] = v[DW-1-i];
        end
        return r;
    endfunction

    // wrap an updated pointer back into the buffer when it steps past a bound
    function automatic logic [DW-1:0] circFix(input logic [DW-1:0] v,
                                              input logic [DW-1:0] lo,
                                              input logic [DW-1:0] hi);
        logic [DW-1:0] len;
        len = DW'(hi - lo + 16'h0001);
        if (v > hi) begin
            return DW'(v - len);
        end else if (v < lo) begin
            return DW'(v + len);
        end
        return v;
    endfunction

    function automatic logic isModify(input agu_pkg::agu_mode_type m);
        return (m == agu_pkg::MODE_POST) || (m == agu_pkg::MODE_PRE);
    endfunction

    logic [DW-1:0] regFile_r [NUM_REGS];
    logic [DW-1:0] circCtrl_r;
    logic [DW-1:0] priStart_r;
    logic [DW-1:0] priEnd_r;
    logic [DW-1:0] secStart_r;
    logic [DW-1:0] secEnd_r;
    logic [DW-1:0] bitRev_r;
    logic [DW-1:0] priEa_r;
    logic priEaValid_r;
    logic priMemAccess_r;
    logic [DW-1:0] priOperand_r;
    logic [DW-1:0] baseOperand_r;
    logic priBitRevActive_r;
    logic [DW-1:0] secEa_r;
    logic secEaValid_r;
    logic secRefused_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    // control fields
    wire [agu_pkg::SEL_W-1:0] priCircSel = circCtrl_r[agu_pkg::PRI_SEL_LSB +: agu_pkg::SEL_W];
    wire [agu_pkg::SEL_W-1:0] secCircSel = circCtrl_r[agu_pkg::SEC_SEL_LSB +: agu_pkg::SEL_W];
    wire [agu_pkg::SEL_W-1:0] revSel = circCtrl_r[agu_pkg::REV_SEL_LSB +: agu_pkg::SEL_W];
    wire priCircOn = circCtrl_r[agu_pkg::PRI_CIRC_EN_BIT]
                     && (priCircSel != agu_pkg::SEL_DISABLED); // RULE20
    wire secCircOn = circCtrl_r[agu_pkg::SEC_CIRC_EN_BIT]
                     && (secCircSel != agu_pkg::SEL_DISABLED); // RULE21
    wire [DW-1:0] priStartVal = {priStart_r[DW-1:1], 1'b0};
    wire [DW-1:0] priEndVal = {priEnd_r[DW-1:1], 1'b1};
    wire [DW-1:0] secStartVal = {secStart_r[DW-1:1], 1'b0};
    wire [DW-1:0] secEndVal = {secEnd_r[DW-1:1], 1'b1};
    wire [DW-1:0] pivot = {bitRev_r[DW-2:0], 1'b0};

    // primary generator
    wire [DW-1:0] priPtr = regFile_r[priPtrSel];
    wire [DW-1:0] priOff = regFile_r[priOffSel];
    wire priCircHit = priCircOn && (priCircSel == priPtrSel);
    wire priIncrement = !priModAmt[DW-1] && (priModAmt != '0);
    wire priBitRev = bitRev_r[agu_pkg::REV_EN_BIT] && (revSel != agu_pkg::SEL_DISABLED)
                     && (revSel == priPtrSel) && isModify(priMode) && priIncrement
                     && priWrite && !priProgSpace; // RULE22 RULE4
    wire [DW-1:0] priLinear = DW'(priPtr + priModAmt); // RULE23
    wire [DW-1:0] priRevSum = rev16(DW'(rev16(priPtr) + rev16(pivot)));
    wire [DW-1:0] priStepped = priBitRev ? priRevSum
                             : priCircHit ? circFix(priLinear, priStartVal, priEndVal)
                             : priLinear; // RULE3
    wire [DW-1:0] priSumReg = DW'(priPtr + priOff); // RULE14
    wire [DW-1:0] priSumLit = DW'(priPtr + priLit); // RULE15
    wire [DW-1:0] priFileAddr = priMoveFull ? priLit // RULE8
                              : {{(DW-agu_pkg::FILE_ADDR_W){1'b0}},
                                 priLit[agu_pkg::FILE_ADDR_W-1:0]}; // RULE5
    wire [DW-1:0] priLitVal = priLitLong
                            ? {{(DW-agu_pkg::LIT_LONG_W){1'b0}}, priLit[agu_pkg::LIT_LONG_W-1:0]}
                            : {{(DW-agu_pkg::LIT_SHORT_W){1'b0}},
                               priLit[agu_pkg::LIT_SHORT_W-1:0]}; // RULE17 RULE19
    logic [DW-1:0] priEaNxt;
    logic priMemNxt;
    logic [DW-1:0] priOperandNxt;
    logic priWb;
    always_comb begin
        priEaNxt = '0;
        priMemNxt = 1'b1;
        priOperandNxt = '0;
        priWb = 1'b0;
        case (priMode)
            agu_pkg::MODE_FILE: begin
                priEaNxt = priFileAddr; // RULE9
                priOperandNxt = regFile_r[0]; // RULE6
            end
            agu_pkg::MODE_REG: begin
                priMemNxt = 1'b0; // RULE10
                priOperandNxt = priPtr;
            end
            agu_pkg::MODE_IND: priEaNxt = priPtr; // RULE11
            agu_pkg::MODE_POST: begin
                priEaNxt = priPtr; // RULE12
                priWb = 1'b1;
            end
            agu_pkg::MODE_PRE: begin
                priEaNxt = priStepped; // RULE13
                priWb = 1'b1;
            end
            agu_pkg::MODE_REGOFF: priEaNxt = priCircHit
                                             ? circFix(priSumReg, priStartVal, priEndVal)
                                             : priSumReg;
            agu_pkg::MODE_LITOFF: priEaNxt = priCircHit
                                             ? circFix(priSumLit, priStartVal, priEndVal)
                                             : priSumLit;
            agu_pkg::MODE_LIT: begin
                priMemNxt = 1'b0;
                priOperandNxt = priLitVal;
            end
            default: priMemNxt = 1'b0;
        endcase
    end

    // secondary generator: word reads only, word aligned
    wire secAccept = secReq && !secWrite && !secByte; // RULE2
    wire [DW-1:0] secPtr = regFile_r[secPtrSel];
    wire [DW-1:0] secLinear = DW'(secPtr + secModAmt);
    wire secCircHit = secCircOn && (secCircSel == secPtrSel);
    wire [DW-1:0] secStepped = secCircHit ? circFix(secLinear, secStartVal, secEndVal)
                             : secLinear;
    wire [DW-1:0] secSumReg = DW'(secPtr + regFile_r[secOffSel]);
    logic [DW-1:0] secEaNxt;
    logic secWb;
    always_comb begin
        secEaNxt = secPtr;
        secWb = 1'b0;
        case (secMode)
            agu_pkg::MODE_POST: secWb = 1'b1;
            agu_pkg::MODE_PRE: begin
                secEaNxt = secStepped;
                secWb = 1'b1;
            end
            agu_pkg::MODE_REGOFF: secEaNxt = secCircHit
                                             ? circFix(secSumReg, secStartVal, secEndVal)
                                             : secSumReg;
            default: secEaNxt = secPtr;
        endcase
    end

    // working register write ports: result, then primary, then secondary
    wire [agu_pkg::SEL_W-1:0] resultDest = resultToZero ? '0 : resultSel; // RULE7 RULE18
    wire priPtrWr = priReq && priWb;
    wire secPtrWr = secAccept && secWb && !(priPtrWr && (priPtrSel == secPtrSel));
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regFile_r[i] <= agu_pkg::REG_RESET;
            end
        end else begin
            if (secPtrWr) begin
                regFile_r[secPtrSel] <= secStepped; // RULE1
            end
            if (priPtrWr) begin
                regFile_r[priPtrSel] <= priStepped; // RULE12 RULE13
            end
            if (resultWrEn) begin
                regFile_r[resultDest] <= resultData;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            priEa_r <= '0;
            priEaValid_r <= 1'b0;
            priMemAccess_r <= 1'b0;
            priOperand_r <= '0;
            baseOperand_r <= '0;
            priBitRevActive_r <= 1'b0;
        end else begin
            priEa_r <= priReq ? priEaNxt : priEa_r;
            priEaValid_r <= priReq && priMemNxt;
            priMemAccess_r <= priReq && priMemNxt;
            priOperand_r <= priReq ? priOperandNxt : priOperand_r;
            baseOperand_r <= regFile_r[baseSel]; // RULE16
            priBitRevActive_r <= priReq && priBitRev;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            secEa_r <= '0;
            secEaValid_r <= 1'b0;
            secRefused_r <= 1'b0;
        end else begin
            secEa_r <= secAccept ? {secEaNxt[DW-1:1], 1'b0} : secEa_r;
            secEaValid_r <= secAccept;
            secRefused_r <= secReq && !secAccept; // RULE2
        end
    end

    // APB slave, one wait state, reads registered
    wire apbAccess = psel && penable && !pready_r;
    wire hitCtrl = (paddr == agu_pkg::ADDR_CIRC_CTRL);
    wire hitPriS = (paddr == agu_pkg::ADDR_PRI_START);
    wire hitPriE = (paddr == agu_pkg::ADDR_PRI_END);
    wire hitSecS = (paddr == agu_pkg::ADDR_SEC_START);
    wire hitSecE = (paddr == agu_pkg::ADDR_SEC_END);
    wire hitRev = (paddr == agu_pkg::ADDR_BIT_REV);
    wire hitPriEa = (paddr == agu_pkg::ADDR_PRI_EA);
    wire hitSecEa = (paddr == agu_pkg::ADDR_SEC_EA);
    wire hitRw = hitCtrl || hitPriS || hitPriE || hitSecS || hitSecE || hitRev;
    wire hitAny = hitRw || hitPriEa || hitSecEa;
    wire regWr = apbAccess && pwrite && hitRw;
    wire [DW-1:0] wData = pwdata[DW-1:0];
    wire [DW-1:0] readMux = hitCtrl ? circCtrl_r
                          : hitPriS ? priStartVal
                          : hitPriE ? priEndVal
                          : hitSecS ? secStartVal
                          : hitSecE ? secEndVal
                          : hitRev ? bitRev_r
                          : hitPriEa ? priEa_r
                          : hitSecEa ? secEa_r
                          : '0;

    always_ff @(posedge clk) begin
        if (rst) begin
            circCtrl_r <= agu_pkg::CTRL_RESET;
            priStart_r <= agu_pkg::START_RESET;
            priEnd_r <= agu_pkg::END_RESET;
            secStart_r <= agu_pkg::START_RESET;
            secEnd_r <= agu_pkg::END_RESET;
            bitRev_r <= agu_pkg::BIT_REV_RESET;
        end else if (regWr) begin
            if (hitCtrl) circCtrl_r <= wData & agu_pkg::CIRC_CTRL_MASK;
            if (hitPriS) priStart_r <= wData;
            if (hitPriE) priEnd_r <= wData;
            if (hitSecS) secStart_r <= wData;
            if (hitSecE) secEnd_r <= wData;
            if (hitRev) bitRev_r <= wData;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
        end else begin
            pready_r <= apbAccess;
            pslverr_r <= apbAccess && !hitAny;
            prdata_r <= (apbAccess && !pwrite) ? {16'h0000, readMux} : 32'h0000_0000;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign priEa = priEa_r;
    assign priEaValid = priEaValid_r;
    assign priMemAccess = priMemAccess_r;
    assign priOperand = priOperand_r;
    assign baseOperand = baseOperand_r;
    assign priBitRevActive = priBitRevActive_r;
    assign secEa = secEa_r;
    assign secEaValid = secEaValid_r;
    assign secRefused = secRefused_r;

    // checks
    wire quietPri = !resultWrEn && !(secPtrWr && secPtrSel == priPtrSel);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_SEC_WORD_ONLY: assert property ( // RULE2
        secReq && (secWrite || secByte) |=> secRefused_r && !secEaValid_r)
        else $error("secondary accepted a write or byte access");
    AST_IND_PLAIN: assert property ( // RULE11
        priReq && priMode == agu_pkg::MODE_IND && quietPri
        |=> priEa_r == $past(priPtr) && regFile_r[$past(priPtrSel)] == $past(priPtr))
        else $error("indirect EA or pointer wrong");
    AST_POST_MOD: assert property ( // RULE12
        priReq && priMode == agu_pkg::MODE_POST && !priCircHit && !priBitRev && quietPri
        |=> priEa_r == $past(priPtr)
            && regFile_r[$past(priPtrSel)] == DW'($past(priPtr) + $past(priModAmt)))
        else $error("post-modify wrong");
    AST_PRE_MOD: assert property ( // RULE13
        priReq && priMode == agu_pkg::MODE_PRE && !priCircHit && !priBitRev && quietPri
        |=> priEa_r == DW'($past(priPtr) + $past(priModAmt))
            && regFile_r[$past(priPtrSel)] == priEa_r)
        else $error("pre-modify wrong");
    AST_REG_OFFSET: assert property ( // RULE14
        priReq && priMode == agu_pkg::MODE_REGOFF && !priCircHit
        |=> priEa_r == DW'($past(priPtr) + $past(priOff)))
        else $error("register offset EA wrong");
    AST_LIT_OFFSET: assert property ( // RULE15
        priReq && priMode == agu_pkg::MODE_LITOFF && !priCircHit
        |=> priEa_r == DW'($past(priPtr) + $past(priLit)))
        else $error("literal offset EA wrong");
    AST_FILE_NEAR: assert property ( // RULE5
        priReq && priMode == agu_pkg::MODE_FILE && !priMoveFull
        |=> priEaValid_r && priEa_r < agu_pkg::NEAR_BYTES)
        else $error("file address left near region");
    AST_REG_DIRECT: assert property ( // RULE10
        priReq && priMode == agu_pkg::MODE_REG
        |=> !priMemAccess_r && priOperand_r == $past(priPtr))
        else $error("register direct made a memory access");
    AST_BASE_OPERAND: assert property ( // RULE16
        ##1 baseOperand_r == $past(regFile_r[baseSel]))
        else $error("base operand stale");
    AST_CIRC_GATE: assert property ( // RULE20
        priReq && priMode == agu_pkg::MODE_POST && !priBitRev && quietPri
        && (!circCtrl_r[agu_pkg::PRI_CIRC_EN_BIT] || priPtrSel == agu_pkg::SEL_DISABLED)
        |=> regFile_r[$past(priPtrSel)] == DW'($past(priPtr) + $past(priModAmt)))
        else $error("circular wrap applied while disabled");

    COV_SEC_READ: cover property (secAccept ##1 secEaValid_r);
    COV_POST_CIRC: cover property (priReq && priMode == agu_pkg::MODE_POST && priCircHit);
    COV_BIT_REV: cover property (priReq && priBitRev);
    COV_APB_WRITE: cover property (regWr ##1 pready_r);
endmodule

// ### testbench/agu_mem_model.sv
`timescale 1ns/1ps
// data memory side: counts the memory accesses that the primary generator issues
module agu_mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic memAccess,
    output logic [7:0] accCount
);
    always_ff @(posedge clk) begin
        if (rst) begin
            accCount <= '0;
        end else if (memAccess) begin
            accCount <= accCount + 8'h01;
        end
    end
endmodule

// ### testbench/test_agu_top.sv
`timescale 1ns/1ps
module test_agu_top;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, priReq = 0, priLitLong = 0;
    logic priMoveFull = 0, priWrite = 0, priProgSpace = 0, secReq = 0, secWrite = 0;
    logic secByte = 0, resultWrEn = 0, resultToZero = 0, pready, pslverr;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    agu_pkg::agu_mode_type priMode = agu_pkg::MODE_IND, secMode = agu_pkg::MODE_IND;
    logic [3:0] priPtrSel = '0, priOffSel = '0, baseSel = '0, secPtrSel = '0;
    logic [3:0] secOffSel = '0, resultSel = '0;
    logic [15:0] priLit = '0, priModAmt = '0, secModAmt = '0, resultData = '0;
    logic [15:0] priEa, priOperand, baseOperand, secEa;
    logic priEaValid, priMemAccess, priBitRevActive, secEaValid, secRefused, er;
    logic [7:0] accCount, cnt0;
    int num_errors = 0, n_checks = 0;
    agu_top agu_top_inst (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .priReq, .priMode, .priPtrSel, .priOffSel, .priLit, .priLitLong,
        .priMoveFull, .priModAmt, .priWrite, .priProgSpace, .baseSel, .secReq, .secMode,
        .secPtrSel, .secOffSel, .secModAmt, .secWrite, .secByte, .resultWrEn, .resultToZero,
        .resultSel, .resultData, .priEa, .priEaValid, .priMemAccess, .priOperand,
        .baseOperand, .priBitRevActive, .secEa, .secEaValid, .secRefused);
    agu_mem_model agu_mem_model_inst (.clk, .rst, .memAccess(priMemAccess), .accCount);
    initial begin
        forever #5 clk = ~clk;
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    task setreg(input logic [3:0] s, input logic [15:0] d, input logic z);
        resultSel <= s;
        resultData <= d;
        resultToZero <= z;
        resultWrEn <= 1;
        @(posedge clk);
        resultWrEn <= 0;
        @(posedge clk);
    endtask
    task pri(input agu_pkg::agu_mode_type m, input logic [3:0] p, input logic [15:0] l,
             input logic [15:0] a);
        priMode <= m;
        priPtrSel <= p;
        priLit <= l;
        priModAmt <= a;
        priReq <= 1;
        @(posedge clk);
        priReq <= 0;
        @(posedge clk);
    endtask
    task test_regs();
        apb(0, agu_pkg::ADDR_CIRC_CTRL, '0);
        chk(rd, 32'h00000000);
        apb(0, agu_pkg::ADDR_PRI_END, '0);
        chk(rd, 32'h00000001);
        apb(0, 12'hFFC, '0);
        chk(er, 1'h1);
        apb(1, agu_pkg::ADDR_BIT_REV, 32'h0000ABCD);
        apb(0, agu_pkg::ADDR_BIT_REV, '0);
        chk(rd, 32'h0000ABCD);
        $display("test regs done");
    endtask
    task test_indirect();
        setreg(4'h3, 16'h1000, 0);
        setreg(4'h4, 16'h0010, 0);
        cnt0 = accCount;
        pri(agu_pkg::MODE_POST, 4'h3, '0, 16'h0002);
        chk(priEa, 16'h1000);
        chk(priEaValid, 1'h1);
        pri(agu_pkg::MODE_IND, 4'h3, '0, '0);
        pri(agu_pkg::MODE_IND, 4'h3, '0, '0);
        chk(priEa, 16'h1002);
        pri(agu_pkg::MODE_PRE, 4'h3, '0, 16'hFFFC);
        chk(priEa, 16'h0FFE);
        priOffSel <= 4'h4;
        pri(agu_pkg::MODE_REGOFF, 4'h3, '0, '0);
        chk(priEa, 16'h100E);
        pri(agu_pkg::MODE_LITOFF, 4'h3, 16'h0020, '0);
        chk(priEa, 16'h101E);
        pri(agu_pkg::MODE_IND, 4'h3, '0, '0);
        chk(priEa, 16'h0FFE);
        @(posedge clk);
        chk(accCount, cnt0 + 8'h07);
        $display("test indirect done");
    endtask
    task test_direct();
        setreg(4'h0, 16'h00AA, 1);
        cnt0 = accCount;
        pri(agu_pkg::MODE_REG, 4'h4, '0, '0);
        chk(priOperand, 16'h0010);
        @(posedge clk);
        chk(accCount, cnt0);
        pri(agu_pkg::MODE_FILE, 4'h4, 16'hFFFF, '0);
        chk(priEa, 16'h1FFF);
        chk(priOperand, 16'h00AA);
        priMoveFull <= 1;
        pri(agu_pkg::MODE_FILE, 4'h4, 16'hFFFF, '0);
        chk(priEa, 16'hFFFF);
        priMoveFull <= 0;
        pri(agu_pkg::MODE_LIT, 4'h4, 16'h03FF, '0);
        chk(priOperand, 16'h001F);
        priLitLong <= 1;
        pri(agu_pkg::MODE_LIT, 4'h4, 16'h03FF, '0);
        chk(priOperand, 16'h03FF);
        baseSel <= 4'h4;
        @(posedge clk);
        @(posedge clk);
        chk(baseOperand, 16'h0010);
        $display("test direct done");
    endtask
    task test_wrap_sec();
        setreg(4'h5, 16'hFFFE, 0);
        pri(agu_pkg::MODE_POST, 4'h5, '0, 16'h0004);
        pri(agu_pkg::MODE_IND, 4'h5, '0, '0);
        chk(priEa, 16'h0002);
        setreg(4'hA, 16'h2001, 0);
        secPtrSel <= 4'hA;
        secReq <= 1;
        pri(agu_pkg::MODE_IND, 4'h5, '0, '0);
        chk(secEa, 16'h2000);
        chk(secEaValid, 1'h1);
        chk(priEa, 16'h0002);
        secWrite <= 1;
        @(posedge clk);
        secReq <= 0;
        secWrite <= 0;
        @(posedge clk);
        chk(secRefused, 1'h1);
        chk(secEaValid, 1'h0);
        secMode <= agu_pkg::MODE_POST;
        secModAmt <= 16'h0004;
        secReq <= 1;
        @(posedge clk);
        secReq <= 0;
        pri(agu_pkg::MODE_IND, 4'hA, '0, '0);
        chk(priEa, 16'h2005);
        $display("test wrap and secondary done");
    endtask
    task test_circ_rev();
        apb(1, agu_pkg::ADDR_PRI_START, 32'h00001000);
        apb(1, agu_pkg::ADDR_PRI_END, 32'h0000100F);
        apb(1, agu_pkg::ADDR_CIRC_CTRL, 32'h0000B7F6);
        apb(1, agu_pkg::ADDR_BIT_REV, 32'h00008008);
        apb(0, agu_pkg::ADDR_CIRC_CTRL, '0);
        chk(rd, 32'h000087F6);
        setreg(4'h6, 16'h100E, 0);
        setreg(4'h7, 16'h2000, 0);
        pri(agu_pkg::MODE_POST, 4'h6, '0, 16'h0004);
        chk(priEa, 16'h100E);
        pri(agu_pkg::MODE_IND, 4'h6, '0, '0);
        chk(priEa, 16'h1002);
        priWrite <= 1;
        pri(agu_pkg::MODE_POST, 4'h7, '0, 16'h0002);
        chk(priBitRevActive, 1'h1);
        priWrite <= 0;
        pri(agu_pkg::MODE_POST, 4'h7, '0, 16'h0002);
        chk(priBitRevActive, 1'h0);
        chk(priEa, 16'h2010);
        $display("test circular and bit-reverse done");
    endtask
    task give_verdict();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #200000;
        num_errors++;
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        test_regs();
        test_indirect();
        test_direct();
        test_wrap_sec();
        test_circ_rev();
        give_verdict();
    end
endmodule
